// ===== dv/asc_regs_test.sv
// self-checking bench for the amplifier status/control register bank
`timescale 1ns/100ps
module asc_regs_test;
	logic clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic [6:0] reg_addr_in = 7'h00;
	logic reg_wr_in = 1'b0;
	logic reg_rd_in = 1'b0;
	logic [7:0] reg_wdata_in = 8'h00;
	logic [7:0] reg_rdata_out;
	logic [1:0] pcm_rate_select_out;
	logic rec_one, rec_two, force_down, boot_flag, power_error_signal;
	logic [5:0] power_flags_in = 6'h00;
	logic boot_in = 1'b0;
	logic tmo_in = 1'b0;
	// [5]=overcurrent .. [0]=conversion done
	logic [5:0] evt = 6'h00;
	int fail_count = 0;
	int n_tests = 0;
	int bitpos[6];
	logic [6:0] addrs[6];

	asc_regs u_dut (.clk_in(clk_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
		.pcm_rate_select_out(pcm_rate_select_out), .clkerr_one_recovery_off_out(rec_one),
		.clkerr_two_recovery_off_out(rec_two), .dummy_powerup_force_down_out(force_down),
		.processor_boot_flag_out(boot_flag), .power_flags_in(power_flags_in), .boot_in_progress_in(boot_in),
		.overcurrent_in(evt[5]), .undervoltage_in(evt[4]), .overtemp_in(evt[3]), .brownout_in(evt[2]),
		.clock_lost_in(evt[1]), .conversion_done_in(evt[0]), .clkerr_timeout_in(tmo_in),
		.power_error_signal_out(power_error_signal));

	// ----------------------------------------
	// bus and check helpers
	// ----------------------------------------
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] v);
		@(posedge clk_in);
		#1;
		reg_addr_in = a;
		reg_wdata_in = v;
		reg_wr_in = 1'b1;
		@(posedge clk_in);
		#1;
		reg_wr_in = 1'b0;
	endtask
	// rdata is registered, so it is taken one edge after the strobe
	task automatic rd_chk(input string what, input logic [6:0] a, input logic [7:0] exp);
		@(posedge clk_in);
		#1;
		reg_addr_in = a;
		reg_rd_in = 1'b1;
		@(posedge clk_in);
		#1;
		reg_rd_in = 1'b0;
		chk(what, reg_rdata_out, exp);
	endtask
	// inputs pass a two-flop synchroniser, so allow a margin
	task automatic settle();
		repeat (4) @(posedge clk_in);
		#1;
	endtask
	task automatic end_sim();
		if (fail_count == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_control();
		logic [1:0] rates[4] = '{asc_pkg::RATE_8K, asc_pkg::RATE_16K, asc_pkg::RATE_48K, asc_pkg::RATE_96K};
		foreach (rates[i]) begin
			wr(asc_pkg::ADDR_PCM_RATE, {6'h00, rates[i]});
			chk("rate pin", {6'h00, pcm_rate_select_out}, {6'h00, rates[i]});
			rd_chk("rate reg", asc_pkg::ADDR_PCM_RATE, {6'h00, rates[i]});
		end
		for (int i = 1; i < 4; i++) begin
			wr(asc_pkg::ADDR_CLK_RECOV, 8'(i));
			chk("recovery pins", {6'h00, rec_two, rec_one}, 8'(i));
			rd_chk("recovery reg", asc_pkg::ADDR_CLK_RECOV, 8'(i));
		end
		wr(asc_pkg::ADDR_DEBUG_ONE, 8'h04);
		chk("force set", {7'h00, force_down}, 8'h01);
		wr(asc_pkg::ADDR_DEBUG_ONE, 8'hfb);
		chk("force clear", {7'h00, force_down}, 8'h00);
		rd_chk("debug reg", asc_pkg::ADDR_DEBUG_ONE, 8'hfb);
	endtask
	task automatic t_status();
		for (int k = 0; k < 6; k++) begin
			power_flags_in = 6'h01 << k;
			settle();
			rd_chk("power", asc_pkg::ADDR_POWER_STATE, 8'h04 << k);
		end
		power_flags_in = 6'h00;
		// status bits 7..2 are read-only: a write sticks only in spare bits 1:0
		wr(asc_pkg::ADDR_POWER_STATE, 8'hff);
		rd_chk("power ro", asc_pkg::ADDR_POWER_STATE, 8'h03);
		boot_in = 1'b1;
		settle();
		chk("boot pin", {7'h00, boot_flag}, 8'h01);
		wr(asc_pkg::ADDR_BOOT_STATE, 8'h00);
		rd_chk("boot busy", asc_pkg::ADDR_BOOT_STATE, 8'h04);
		boot_in = 1'b0;
		settle();
		// wait up to eight edges until boot shows complete
		for (int n = 0; n < 8 && boot_flag !== 1'b0; n++) begin
			@(posedge clk_in);
		end
		chk("boot wait", {7'h00, boot_flag}, 8'h00);
		rd_chk("boot done", asc_pkg::ADDR_BOOT_STATE, 8'h00);
	endtask
	task automatic t_events();
		foreach (bitpos[j]) begin
			@(posedge clk_in);
			#1;
			evt[j] = 1'b1;
			@(posedge clk_in);
			#1;
			evt[j] = 1'b0;
			settle();
			rd_chk("latch set", asc_pkg::ADDR_FAULT_LATCH, 8'h01 << bitpos[j]);
			rd_chk("latch clr", asc_pkg::ADDR_FAULT_LATCH, 8'h00);
		end
		evt = 6'h21;
		settle();
		evt = 6'h00;
		wr(asc_pkg::ADDR_FAULT_LATCH, 8'h00);
		rd_chk("latch both", asc_pkg::ADDR_FAULT_LATCH, 8'h82);
		// a condition still present during the read is latched again
		evt[3] = 1'b1;
		settle();
		rd_chk("held first", asc_pkg::ADDR_FAULT_LATCH, 8'h10);
		rd_chk("held again", asc_pkg::ADDR_FAULT_LATCH, 8'h10);
		evt[3] = 1'b0;
		settle();
		rd_chk("held last", asc_pkg::ADDR_FAULT_LATCH, 8'h10);
		rd_chk("held gone", asc_pkg::ADDR_FAULT_LATCH, 8'h00);
		rd_chk("unmapped", 7'h10, 8'h00);
		tmo_in = 1'b1;
		settle();
		tmo_in = 1'b0;
		settle();
		chk("power error", {7'h00, power_error_signal}, 8'h01);
	endtask
	// reset in mid-run clears sticky error and control registers
	task automatic t_midreset();
		wr(asc_pkg::ADDR_CLK_RECOV, 8'h03);
		@(posedge clk_in);
		#1;
		reset_in = 1'b1;
		repeat (2) @(posedge clk_in);
		#1;
		reset_in = 1'b0;
		chk("reset again", {1'b0, pcm_rate_select_out, rec_one, rec_two, force_down, boot_flag, power_error_signal}, 8'h00);
		rd_chk("recov reset", asc_pkg::ADDR_CLK_RECOV, 8'h00);
	endtask

	initial begin
		forever #5 clk_in = ~clk_in;
	end
	initial begin
		#500000;
		fail_count++;
		end_sim();
	end
	initial begin
		bitpos = '{asc_pkg::LAT_SC_BIT, asc_pkg::LAT_CL_BIT, asc_pkg::LAT_BO_BIT, asc_pkg::LAT_OT_BIT,
			asc_pkg::LAT_UV_BIT, asc_pkg::LAT_OC_BIT};
		addrs = '{asc_pkg::ADDR_PCM_RATE, asc_pkg::ADDR_CLK_RECOV, asc_pkg::ADDR_DEBUG_ONE,
			asc_pkg::ADDR_POWER_STATE, asc_pkg::ADDR_BOOT_STATE, asc_pkg::ADDR_FAULT_LATCH};
		repeat (16) @(posedge clk_in);
		#1;
		reset_in = 1'b0;
		foreach (addrs[j]) begin
			rd_chk("reset", addrs[j], 8'h00);
		end
		rd_chk("reset latch", asc_pkg::ADDR_FAULT_LATCH, 8'h00);
		chk("reset pins", {1'b0, pcm_rate_select_out, rec_one, rec_two, force_down, boot_flag, power_error_signal}, 8'h00);
		t_control();
		t_status();
		t_events();
		t_midreset();
		end_sim();
	end
endmodule

// ===== rtl/asc_pkg.sv
// package: offsets, fields, reset values and timing for the amplifier status/control bank
package asc_pkg;
	localparam logic [6:0] ADDR_PCM_RATE = 7'h2f;
	localparam logic [6:0] ADDR_CLK_RECOV = 7'h32;
	localparam logic [6:0] ADDR_DEBUG_ONE = 7'h35;
	localparam logic [6:0] ADDR_POWER_STATE = 7'h64;
	localparam logic [6:0] ADDR_BOOT_STATE = 7'h65;
	localparam logic [6:0] ADDR_FAULT_LATCH = 7'h68;
	localparam logic [7:0] RESET_VALUE = 8'h00;
	localparam int PCM_RATE_LSB = 0;
	localparam int CLKERR_TWO_BIT = 1;
	localparam int CLKERR_ONE_BIT = 0;
	localparam int FORCE_DOWN_BIT = 2;
	localparam int BOOT_FLAG_BIT = 2;
	localparam int POWER_FLAG_LSB = 2;
	localparam int LAT_OC_BIT = 7;
	localparam int LAT_UV_BIT = 6;
	localparam int LAT_OT_BIT = 4;
	localparam int LAT_BO_BIT = 3;
	localparam int LAT_CL_BIT = 2;
	localparam int LAT_SC_BIT = 1;
	localparam logic [7:0] LATCH_MASK = 8'hde;
	localparam logic [1:0] RATE_8K = 2'h0;
	localparam logic [1:0] RATE_16K = 2'h1;
	localparam logic [1:0] RATE_48K = 2'h2;
	localparam logic [1:0] RATE_96K = 2'h3;
	localparam int CLK_HZ = 100000000;
	localparam int TMO_MIN_US100 = 27;
	localparam int TMO_MAX_MS = 1400;
	localparam longint TMO_MIN_CYC = (longint'(TMO_MIN_US100) * CLK_HZ + 9999) / 10000;
	localparam longint TMO_MAX_CYC = longint'(TMO_MAX_MS) * CLK_HZ / 1000;
endpackage

// ===== rtl/asc_regs.sv
// register bank: pcm rate, clock-error recovery, debug force, power/boot status, fault latches
`timescale 1ns/100ps
// What this block does
// - bits 1:0 pick pcm sample rate 8/16/48/96 kHz, reset zero.
// - recovery bit 1 for detector two, bit 0 detector one; 1 disables.
// - debug bit 2 forces dummy power-up sequence down while set.
// - power status bits 7..2 show live dac, output, boost, passthru, isense, vsense.
// - boot status bit 2 shows processor boot state, read-only, reset zero.
// - fault latch bits stay set; reading returns them then clears all except those whose event is present in the read cycle.
// - bit 7 latches speaker over-current since last read.
// - bit 6 latches analog under-voltage since last read.
// - bit 4 latches die over-temperature since last read.
// - bit 3 latches brownout since last read.
// - bit 2 latches lost clock since last read.
// - bit 1 latches conversion complete since last read.
// - clock-error detector timeout input sets a sticky power error flag.
module asc_regs (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic [6:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_wdata_in,
	output logic [7:0] reg_rdata_out,
	output logic [1:0] pcm_rate_select_out,
	output logic clkerr_one_recovery_off_out,
	output logic clkerr_two_recovery_off_out,
	output logic dummy_powerup_force_down_out,
	output logic processor_boot_flag_out,
	input wire logic [5:0] power_flags_in,
	input wire logic boot_in_progress_in,
	input wire logic overcurrent_in,
	input wire logic undervoltage_in,
	input wire logic overtemp_in,
	input wire logic brownout_in,
	input wire logic clock_lost_in,
	input wire logic conversion_done_in,
	input wire logic clkerr_timeout_in,
	output logic power_error_signal_out
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] rdata;
		logic [1:0] pcm_rate_select;
		logic [5:0] pcm_spare;
		logic [1:0] recov_off;
		logic [5:0] recov_spare;
		logic [7:0] debug_one;
		logic [1:0] power_spare;
		logic [7:0] fault_latch;
		logic power_error;
	} asc_regs_state_t;
	asc_regs_state_t st_r;
	asc_regs_state_t st_nxt;
	logic [7:0] async_raw;
	logic [7:0] sync_v;
	logic [5:0] power_flags;
	logic boot_flag;
	logic [7:0] events;
	logic rd_fault;

	// ------------------------------------------------------------
	// pin inputs
	// ------------------------------------------------------------
	// status pins come from analog domains, so every one is synchronised
	assign async_raw = {overcurrent_in, undervoltage_in, overtemp_in, brownout_in,
		clock_lost_in, conversion_done_in, clkerr_timeout_in, boot_in_progress_in};
	asc_sync #(.WIDTH(8)) u_sync_ev (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.async_in(async_raw),
		.sync_out(sync_v)
	);
	asc_sync #(.WIDTH(6)) u_sync_pw (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.async_in(power_flags_in),
		.sync_out(power_flags)
	);
	assign boot_flag = sync_v[0];
	always_comb begin
		events = 8'h00;
		events[asc_pkg::LAT_OC_BIT] = sync_v[7];
		events[asc_pkg::LAT_UV_BIT] = sync_v[6];
		events[asc_pkg::LAT_OT_BIT] = sync_v[5];
		events[asc_pkg::LAT_BO_BIT] = sync_v[4];
		events[asc_pkg::LAT_CL_BIT] = sync_v[3];
		events[asc_pkg::LAT_SC_BIT] = sync_v[2];
	end
	assign rd_fault = reg_rd_in && (reg_addr_in == asc_pkg::ADDR_FAULT_LATCH);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		if (reg_wr_in) begin
			unique case (reg_addr_in)
				asc_pkg::ADDR_PCM_RATE: begin
					{st_nxt.pcm_spare, st_nxt.pcm_rate_select} = reg_wdata_in;
				end
				asc_pkg::ADDR_CLK_RECOV: begin
					{st_nxt.recov_spare, st_nxt.recov_off} = reg_wdata_in;
				end
				asc_pkg::ADDR_DEBUG_ONE: begin
					st_nxt.debug_one = reg_wdata_in;
				end
				asc_pkg::ADDR_POWER_STATE: begin
					st_nxt.power_spare = reg_wdata_in[1:0];
				end
				asc_pkg::ADDR_FAULT_LATCH: begin
					st_nxt.fault_latch[0] = reg_wdata_in[0];
				end
				default: begin
				end
			endcase
		end
		// clear on read, but a new event in the read cycle still lands
		if (rd_fault) begin
			st_nxt.fault_latch = (st_nxt.fault_latch & ~asc_pkg::LATCH_MASK) | events;
		end else begin
			st_nxt.fault_latch = st_nxt.fault_latch | events;
		end
		// timeout comes from the detector; this bank only latches the error
		st_nxt.power_error = st_r.power_error | sync_v[1];
		st_nxt.rdata = st_r.rdata;
		if (reg_rd_in) begin
			unique case (reg_addr_in)
				asc_pkg::ADDR_PCM_RATE: st_nxt.rdata = {st_r.pcm_spare, st_r.pcm_rate_select};
				asc_pkg::ADDR_CLK_RECOV: st_nxt.rdata = {st_r.recov_spare, st_r.recov_off};
				asc_pkg::ADDR_DEBUG_ONE: st_nxt.rdata = st_r.debug_one;
				asc_pkg::ADDR_POWER_STATE: st_nxt.rdata = {power_flags, st_r.power_spare};
				asc_pkg::ADDR_BOOT_STATE: st_nxt.rdata = {5'h00, boot_flag, 2'h0};
				asc_pkg::ADDR_FAULT_LATCH: st_nxt.rdata = st_r.fault_latch;
				default: st_nxt.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign reg_rdata_out = st_r.rdata;
	assign pcm_rate_select_out = st_r.pcm_rate_select;
	assign clkerr_two_recovery_off_out = st_r.recov_off[asc_pkg::CLKERR_TWO_BIT];
	assign clkerr_one_recovery_off_out = st_r.recov_off[asc_pkg::CLKERR_ONE_BIT];
	assign dummy_powerup_force_down_out = st_r.debug_one[asc_pkg::FORCE_DOWN_BIT];
	assign processor_boot_flag_out = sync_v[0];
	assign power_error_signal_out = st_r.power_error;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	chk_rate_write: assert property (@(posedge clk_in) disable iff (reset_in)
		reg_wr_in && reg_addr_in == asc_pkg::ADDR_PCM_RATE |=> pcm_rate_select_out == $past(reg_wdata_in[1:0]))
		else $error("pcm rate not stored");
	chk_recov_write: assert property (@(posedge clk_in) disable iff (reset_in)
		reg_wr_in && reg_addr_in == asc_pkg::ADDR_CLK_RECOV |=>
		{clkerr_two_recovery_off_out, clkerr_one_recovery_off_out} == $past(reg_wdata_in[1:0]))
		else $error("recovery bits not stored");
	chk_force_down: assert property (@(posedge clk_in) disable iff (reset_in)
		reg_wr_in && reg_addr_in == asc_pkg::ADDR_DEBUG_ONE |=> dummy_powerup_force_down_out == $past(reg_wdata_in[2]))
		else $error("force down mismatch");
	chk_power_read: assert property (@(posedge clk_in) disable iff (reset_in)
		reg_rd_in && reg_addr_in == asc_pkg::ADDR_POWER_STATE |=> reg_rdata_out[7:2] == $past(power_flags))
		else $error("power status read wrong");
	chk_boot_read: assert property (@(posedge clk_in) disable iff (reset_in)
		reg_rd_in && reg_addr_in == asc_pkg::ADDR_BOOT_STATE |=> reg_rdata_out == {5'h00, $past(boot_flag), 2'h0})
		else $error("boot status read wrong");
	chk_latch_clear: assert property (@(posedge clk_in) disable iff (reset_in)
		rd_fault && events == 8'h00 |=> (st_r.fault_latch & asc_pkg::LATCH_MASK) == 8'h00)
		else $error("latch not cleared by read");
	chk_oc_sticky: assert property (@(posedge clk_in) disable iff (reset_in)
		events[asc_pkg::LAT_OC_BIT] ##1 !rd_fault [*2] |-> st_r.fault_latch[asc_pkg::LAT_OC_BIT])
		else $error("over-current not held");
	chk_bo_set: assert property (@(posedge clk_in) disable iff (reset_in)
		events[asc_pkg::LAT_BO_BIT] |=> st_r.fault_latch[asc_pkg::LAT_BO_BIT])
		else $error("brownout not latched");
	chk_power_error: assert property (@(posedge clk_in) disable iff (reset_in)
		sync_v[1] |=> power_error_signal_out)
		else $error("power error not raised");

	// ------------------------------------------------------------
	// checks on the latches and on held values
	// ------------------------------------------------------------
	// one check per source, so a swapped pin shows up by name
	chk_uv_set: assert property (@(posedge clk_in) disable iff (reset_in)
		events[asc_pkg::LAT_UV_BIT] |=> st_r.fault_latch[asc_pkg::LAT_UV_BIT])
		else $error("under-voltage not latched");
	chk_ot_set: assert property (@(posedge clk_in) disable iff (reset_in)
		events[asc_pkg::LAT_OT_BIT] |=> st_r.fault_latch[asc_pkg::LAT_OT_BIT])
		else $error("over-temperature not latched");
	chk_cl_set: assert property (@(posedge clk_in) disable iff (reset_in)
		events[asc_pkg::LAT_CL_BIT] |=> st_r.fault_latch[asc_pkg::LAT_CL_BIT])
		else $error("lost clock not latched");
	chk_sc_set: assert property (@(posedge clk_in) disable iff (reset_in)
		events[asc_pkg::LAT_SC_BIT] |=> st_r.fault_latch[asc_pkg::LAT_SC_BIT])
		else $error("conversion done not latched");
	// a read leaves only the events of its own cycle: set wins over clear
	chk_read_clear: assert property (@(posedge clk_in) disable iff (reset_in)
		rd_fault |=> (st_r.fault_latch & asc_pkg::LATCH_MASK) == $past(events))
		else $error("read clear wrong");
	chk_latch_sticky: assert property (@(posedge clk_in) disable iff (reset_in)
		!rd_fault |=> (st_r.fault_latch & asc_pkg::LATCH_MASK) ==
		($past(st_r.fault_latch | events) & asc_pkg::LATCH_MASK))
		else $error("latch bits lost or set by write");
	chk_rate_hold: assert property (@(posedge clk_in) disable iff (reset_in)
		!(reg_wr_in && reg_addr_in == asc_pkg::ADDR_PCM_RATE) |=> $stable(pcm_rate_select_out))
		else $error("pcm rate changed without write");
	chk_error_sticky: assert property (@(posedge clk_in) disable iff (reset_in)
		power_error_signal_out |=> power_error_signal_out)
		else $error("power error dropped");
endmodule

// ===== rtl/asc_sync.sv
// two-flop synchroniser, one per bit
`timescale 1ns/100ps
module asc_sync #(
	parameter int WIDTH = 8
) (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stab;
	} asc_sync_state_t;
	asc_sync_state_t st_r;
	asc_sync_state_t st_nxt;
	always_comb begin
		st_nxt.meta = async_in;
		st_nxt.stab = st_r.meta;
	end
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign sync_out = st_r.stab;
endmodule
